/* File: testbench/bfd_host_model.sv */
// host side model issuing single-word reads on the status read port
`timescale 1ns/1ps
`default_nettype none
module bfd_host_model
	import bfd_pkg::*;
(
	input  wire logic       sys_clk,  // system clock
	output var  logic       rd_req,   // read strobe
	output var  logic [6:0] rd_addr,  // register offset
	input  wire bfd_word_t  rd_data,  // read answer
	input  wire logic       rd_valid  // answer strobe
);
	initial begin
		rd_req = 1'b0;
		rd_addr = 7'h00;
	end
	// one read: strobe held one cycle, answer taken the edge after
	task automatic read(input logic [6:0] a, output bfd_word_t w,
		output logic ok);
		@(posedge sys_clk);
		#1 rd_req = 1'b1;
		rd_addr = a;
		@(posedge sys_clk);
		#1 rd_req = 1'b0;
		// offset inverted so a stale address never looks deliberate
		rd_addr = ~a;
		ok = rd_valid;
		w = rd_data;
	endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the fault and delay status registers
`timescale 1ns/1ps
`default_nettype none
module testbench
	import bfd_pkg::*;
;
	logic            sys_clk;
	logic            rst_n;
	logic            soft_rst;
	logic            restart;
	bfd_flags_t      ov_event;
	logic [1:0]      dly_upd;
	logic [1:0][5:0] on_c;
	logic [1:0][5:0] off_c;
	logic            rd_req;
	logic [6:0]      rd_addr;
	bfd_word_t       rd_data;
	logic            rd_valid;
	integer          n_mismatch = 0;
	integer          n_tests = 0;

	bfd_status_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.soft_rst(soft_rst), .restart(restart), .ov_event(ov_event),
		.dly_upd(dly_upd), .turnon_code(on_c), .turnoff_code(off_c),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_valid(rd_valid));
	bfd_host_model i_host (.sys_clk(sys_clk), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input bfd_word_t e, bfd_word_t g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read one word; answer strobe must come on the next edge
	task automatic rdchk(input string nm, input logic [6:0] a, bfd_word_t e);
		bfd_word_t w;
		logic      ok;
		i_host.read(a, w, ok);
		chk("rd_valid", 16'h0001, {15'h0000, ok});
		chk(nm, e, w);
	endtask

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	// single event pulse of one cycle
	task automatic hit(input bfd_flags_t f);
		tick();
		ov_event = f;
		tick();
		ov_event = '0;
	endtask

	task automatic t_reset();
		rdchk("ov", 7'h52, 16'h0000);
		rdchk("dly1", 7'h53, 16'h0000);
		rdchk("dly2", 7'h54, 16'h0000);
		rdchk("unmapped", 7'h55, 16'h0000);
	endtask

	// each flag lands on its own bit and clears after one read
	task automatic t_flags();
		for (int k = 0; k < 14; k++) begin
			hit(14'h0001 << k);
			rdchk("flag", 7'h52, 16'h0001 << k);
			rdchk("cleared", 7'h52, 16'h0000);
		end
		hit(14'h3FFF);
		rdchk("all", 7'h52, 16'h3FFF);
	endtask

	// event arriving in the read cycle must survive the clear
	task automatic t_race();
		hit(14'h0001);
		fork
			rdchk("race", 7'h52, 16'h0001);
			begin
				tick();
				ov_event = 14'h0002;
				tick();
				ov_event = '0;
			end
		join
		rdchk("kept", 7'h52, 16'h0002);
	endtask

	task automatic t_delay();
		tick();
		on_c = {6'h2A, 6'h3F};
		off_c = {6'h01, 6'h15};
		dly_upd = 2'b11;
		tick();
		dly_upd = 2'b00;
		on_c = '1;
		off_c = '1;
		rdchk("dly1", 7'h53, 16'h153F);
		rdchk("dly2", 7'h54, 16'h012A);
		hit(14'h2000);
		tick();
		restart = 1'b1;
		tick();
		restart = 1'b0;
		rdchk("rs dly1", 7'h53, 16'h153F);
		rdchk("rs dly2", 7'h54, 16'h012A);
		rdchk("rs ov", 7'h52, 16'h2000);
		hit(14'h0100);
		tick();
		soft_rst = 1'b1;
		tick();
		soft_rst = 1'b0;
		rdchk("sr ov", 7'h52, 16'h0000);
		rdchk("sr dly1", 7'h53, 16'h0000);
		rdchk("sr dly2", 7'h54, 16'h0000);
	endtask

	// power-on reset in mid-run clears live flags and both codes
	task automatic t_por();
		dly_upd = 2'b11;
		hit(14'h2081);
		dly_upd = 2'b00;
		rdchk("por pre", 7'h53, 16'h3F3F);
		rst_n = 1'b0;
		repeat (2) tick();
		rst_n = 1'b1;
		rdchk("por ov", 7'h52, 16'h0000);
		rdchk("por dly1", 7'h53, 16'h0000);
		rdchk("por dly2", 7'h54, 16'h0000);
	endtask

	// watchdog well beyond the fewer than 200 cycles the tests need
	initial begin
		#(25 * 5000);
		n_mismatch++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		soft_rst = 1'b0;
		restart = 1'b0;
		ov_event = '0;
		dly_upd = 2'b00;
		on_c = '0;
		off_c = '0;
		repeat (10) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_flags();
		t_race();
		t_delay();
		t_por();
		complete_run();
	end
endmodule
`default_nettype wire

/* File: verilog/bfd_delay_reg.sv */
// one half-bridge effective turn-on/turn-off delay register
`timescale 1ns/1ps
`default_nettype none
`include "bfd_map.svh"
module bfd_delay_reg
	import bfd_pkg::*;
(
	input  wire logic      sys_clk,      // system clock
	input  wire logic      rst_n,        // async reset, active low
	input  wire logic      soft_rst,     // soft reset pulse
	input  wire bfd_code_t turnon_code,  // measured turn-on code
	input  wire bfd_code_t turnoff_code, // measured turn-off code
	input  wire logic      upd,          // load new codes
	output var  bfd_word_t word          // register image
);
	bfd_code_t on_q, on_d;
	bfd_code_t off_q, off_d;

	// restart is not seen here: codes must survive it
	always_comb begin
		on_d  = on_q;
		off_d = off_q;
		if (soft_rst) begin
			on_d  = `BFD_CODE_RST;
			off_d = `BFD_CODE_RST;
		end else if (upd) begin
			on_d  = turnon_code;
			off_d = turnoff_code;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q  <= `BFD_CODE_RST;
			off_q <= `BFD_CODE_RST;
		end else begin
			on_q  <= on_d;
			off_q <= off_d;
		end
	end

	// reserved pairs are constant zero, no storage behind them
	assign word = {2'h0, off_q, 2'h0, on_q};
endmodule
`default_nettype wire

/* File: verilog/bfd_map.svh */
// register offsets, field positions, reset values and timing for the block
`ifndef BFD_MAP_SVH
`define BFD_MAP_SVH

`define BFD_ADDR_W        7
`define BFD_OV_ADDR       7'h52
`define BFD_DLY1_ADDR     7'h53
`define BFD_DLY2_ADDR     7'h54

`define BFD_DATA_W        16
`define BFD_FLAG_W        14
`define BFD_RES_HI_MSB    15
`define BFD_RES_HI_LSB    14
`define BFD_IS_BRAKE_BIT  13
`define BFD_MS_BRAKE_BIT  12
`define BFD_LS_BRK_MSB    11
`define BFD_LS_BRK_LSB    8
`define BFD_SW_OV_MSB     7
`define BFD_SW_OV_LSB     0

`define BFD_CODE_W        6
`define BFD_OFF_MSB       13
`define BFD_OFF_LSB       8
`define BFD_ON_MSB        5
`define BFD_ON_LSB        0
`define BFD_NBRIDGE       2

`define BFD_WORD_RST      16'h0000
`define BFD_FLAGS_RST     14'h0000
`define BFD_CODE_RST      6'h00

// one delay code step, in picoseconds
`define BFD_DELAY_STEP_PS 53300

`endif

/* File: verilog/bfd_pkg.sv */
// shared types of the fault and delay status registers
`default_nettype none
package bfd_pkg;
	typedef logic [5:0]  bfd_code_t;
	typedef logic [15:0] bfd_word_t;
	typedef logic [13:0] bfd_flags_t;
	typedef enum logic [1:0] {
		BFD_SEL_NONE = 2'b00,
		BFD_SEL_OV   = 2'b01,
		BFD_SEL_DLY1 = 2'b10,
		BFD_SEL_DLY2 = 2'b11
	} bfd_sel_t;
endpackage
`default_nettype wire

/* File: verilog/bfd_status_regs.sv */
// overvoltage flags and effective delay registers with read port
`timescale 1ns/1ps
`default_nettype none
`include "bfd_map.svh"
module bfd_status_regs
	import bfd_pkg::*;
(
	input  wire logic                    sys_clk,      // 40 MHz clock
	input  wire logic                    rst_n,        // power-on, low
	input  wire logic                    soft_rst,     // soft reset pulse
	input  wire logic                    restart,      // restart pulse
	input  wire bfd_flags_t              ov_event,     // detector hits
	input  wire logic [1:0]              dly_upd,      // per-bridge load
	input  wire logic [1:0][5:0]         turnon_code,  // per bridge
	input  wire logic [1:0][5:0]         turnoff_code, // per bridge
	input  wire logic                    rd_req,       // read strobe
	input  wire logic [`BFD_ADDR_W-1:0]  rd_addr,      // register offset
	output var  bfd_word_t               rd_data,      // read answer
	output var  logic                    rd_valid      // answer strobe
);
	bfd_flags_t flags_q, flags_d;
	bfd_word_t  rd_data_q, rd_data_d;
	logic       rd_valid_q, rd_valid_d;
	bfd_sel_t   sel;
	bfd_word_t  dly_word [`BFD_NBRIDGE];
	logic       ov_read;

	// one delay register per bridge
	genvar gi;
	generate
		for (gi = 0; gi < `BFD_NBRIDGE; gi++) begin : g_bridge
			bfd_delay_reg u_dly (
				.sys_clk      (sys_clk),
				.rst_n        (rst_n),
				.soft_rst     (soft_rst),
				.turnon_code  (turnon_code[gi]),
				.turnoff_code (turnoff_code[gi]),
				.upd          (dly_upd[gi]),
				.word         (dly_word[gi])
			);
		end
	endgenerate

	// address decode; unmapped offsets answer zero
	always_comb begin
		case (rd_addr)
		`BFD_OV_ADDR:   sel = BFD_SEL_OV;
		`BFD_DLY1_ADDR: sel = BFD_SEL_DLY1;
		`BFD_DLY2_ADDR: sel = BFD_SEL_DLY2;
		default:        sel = BFD_SEL_NONE;
		endcase
	end
	assign ov_read = rd_req && (sel == BFD_SEL_OV);

	// sticky flags: set beats the read clear so no hit is lost
	always_comb begin
		flags_d = flags_q;
		if (soft_rst) begin
			flags_d = `BFD_FLAGS_RST;
		end else begin
			if (ov_read) begin
				flags_d = `BFD_FLAGS_RST;
			end
			flags_d = flags_d | ov_event;
		end
		// restart deliberately has no term here
	end

	// read answer registered, one cycle after the strobe
	always_comb begin
		rd_valid_d = rd_req;
		rd_data_d  = rd_data_q;
		if (rd_req) begin
			case (sel)
			BFD_SEL_OV:   rd_data_d = {2'h0, flags_q};
			BFD_SEL_DLY1: rd_data_d = dly_word[0];
			BFD_SEL_DLY2: rd_data_d = dly_word[1];
			default:      rd_data_d = `BFD_WORD_RST;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q    <= `BFD_FLAGS_RST;
			rd_data_q  <= `BFD_WORD_RST;
			rd_valid_q <= 1'b0;
		end else begin
			flags_q    <= flags_d;
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign rd_data  = rd_data_q;
	assign rd_valid = rd_valid_q;

	// checks on the read path, the sticky flags and the delay registers
	sequence s_ov_read;
		ov_read && !soft_rst;
	endsequence

	sequence s_answer;
		rd_valid;
	endsequence

	property p_res_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		s_ov_read |=> s_answer ##0 (rd_data[15:14] == 2'h0);
	endproperty
	a_res_zero: assert property (p_res_zero)
		else $error("reserved overvoltage bits read nonzero");

	property p_is_brake_set;
		@(posedge sys_clk) disable iff (!rst_n)
		(ov_event[13] && !soft_rst)
			|=> flags_q[13] until_with (ov_read || soft_rst);
	endproperty
	a_is_brake_set: assert property (p_is_brake_set)
		else $error("internal supply brake flag not held");

	property p_ms_brake_clr;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_ov_read ##0 !ov_event[12]) |=> !flags_q[12];
	endproperty
	a_ms_brake_clr: assert property (p_ms_brake_clr)
		else $error("main supply brake flag not cleared by read");

	property p_ls_brk_set;
		@(posedge sys_clk) disable iff (!rst_n)
		(ov_event[11:8] != 4'h0 && !soft_rst)
			|=> ((flags_q[11:8] & $past(ov_event[11:8]))
				== $past(ov_event[11:8]));
	endproperty
	a_ls_brk_set: assert property (p_ls_brk_set)
		else $error("braking overvoltage flag missed");

	property p_ov_readback;
		@(posedge sys_clk) disable iff (!rst_n)
		s_ov_read |=> (rd_data[13:0] == $past(flags_q));
	endproperty
	a_ov_readback: assert property (p_ov_readback)
		else $error("overvoltage read does not show flags");

	property p_soft_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		soft_rst |=> (flags_q == 14'h0000) && (dly_word[0] == 16'h0000)
			&& (dly_word[1] == 16'h0000);
	endproperty
	a_soft_clear: assert property (p_soft_clear)
		else $error("soft reset left state behind");

	property p_restart_keeps;
		@(posedge sys_clk) disable iff (!rst_n)
		(restart && !soft_rst && !rd_req && ov_event == 14'h0000
			&& dly_upd == 2'b00)
			|=> $stable(flags_q) && $stable(dly_word[0])
				&& $stable(dly_word[1]);
	endproperty
	a_restart_keeps: assert property (p_restart_keeps)
		else $error("restart disturbed a live field");

	property p_dly1_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_req && sel == BFD_SEL_DLY1) |=> rd_valid
			&& (rd_data[13:8] == $past(dly_word[0][13:8]))
			&& (rd_data[7:6] == 2'h0);
	endproperty
	a_dly1_read: assert property (p_dly1_read)
		else $error("bridge 1 delay read wrong");

	property p_dly2_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_req && sel == BFD_SEL_DLY2 && !dly_upd[1] && !soft_rst)
			|=> rd_valid && (rd_data[5:0] == dly_word[1][5:0])
			&& (rd_data[15:14] == 2'h0);
	endproperty
	a_dly2_read: assert property (p_dly2_read)
		else $error("bridge 2 delay read wrong");

	property p_event_in_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_ov_read ##0 ov_event != 14'h0000)
			|=> (flags_q == $past(ov_event));
	endproperty
	a_event_in_read: assert property (p_event_in_read)
		else $error("event lost during clear-on-read");

	// switch flags must drop after a read that brings no new hit
	property p_sw_ov_clr;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_ov_read ##0 ov_event[7:0] == 8'h00)
			|=> (flags_q[7:0] == 8'h00);
	endproperty
	a_sw_ov_clr: assert property (p_sw_ov_clr)
		else $error("switch overvoltage flags not cleared by read");

	property p_ls_brk_clr;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_ov_read ##0 ov_event[11:8] == 4'h0)
			|=> (flags_q[11:8] == 4'h0);
	endproperty
	a_ls_brk_clr: assert property (p_ls_brk_clr)
		else $error("braking overvoltage flags not cleared by read");

	// a load strobe must carry both codes into the bridge 1 image
	property p_load_b1;
		@(posedge sys_clk) disable iff (!rst_n)
		(dly_upd[0] && !soft_rst)
			|=> (dly_word[0][5:0] == $past(turnon_code[0]))
				&& (dly_word[0][13:8] == $past(turnoff_code[0]));
	endproperty
	a_load_b1: assert property (p_load_b1)
		else $error("bridge 1 delay codes not loaded");

	// answer strobe is a single pulse and the word holds between reads
	property p_valid_pulse;
		@(posedge sys_clk) disable iff (!rst_n)
		!rd_req |=> !rd_valid && $stable(rd_data);
	endproperty
	a_valid_pulse: assert property (p_valid_pulse)
		else $error("read answer changed without a read");
endmodule
`default_nettype wire
